// File: ddc_source.sv
// DDC master model standing in for the video source
`timescale 1ns/10ps

module ddc_source (
  // Clock
  input wire logic clk,
  // Bus wire level and own drive
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // SDA only moves while SCL is low
  task automatic bitx(input logic l, output logic s);
    @(posedge clk);
    scl <= 1'b0;
    tick(4);
    sda_low <= l;
    tick(4);
    scl <= 1'b1;
    tick(8);
    s = sda_line;
  endtask

  task automatic start(input logic rep);
    logic s;
    if (rep) bitx(1'b0, s);
    @(posedge clk);
    sda_low <= 1'b1;
    tick(8);
  endtask

  task automatic stop();
    logic s;
    bitx(1'b1, s);
    @(posedge clk);
    sda_low <= 1'b0;
    tick(8);
  endtask

  task automatic wr(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(!b[i], s);
    bitx(1'b0, s);
    ack = !s;
  endtask

  task automatic rd(output logic [7:0] b, input logic last);
    logic s;
    b = 8'h00;
    for (int i = 0; i < 8; i++) begin
      bitx(1'b0, s);
      b = {b[6:0], s};
    end
    bitx(!last, s);
  endtask

  // Pointer write, repeated start, sequential read
  task automatic xfer(input logic [7:0] ptr, input int n,
                      output logic ok, output logic [31:0] q);
    logic a0, a1, a2;
    logic [7:0] b;
    q = 32'h0;
    start(1'b0);
    wr(8'hA0, a0);
    wr(ptr, a1);
    start(1'b1);
    wr(8'hA1, a2);
    ok = a0 & a1 & a2;
    for (int i = 0; i < n; i++) begin
      rd(b, i == n - 1);
      q = {q[23:0], b};
    end
    stop();
  endtask
endmodule

// File: edid_delivery_and_hotplug.sv
// Display identification delivery over DDC with sink hot-plug control
// Overview of operation
// - Four identification sources: local, SRAM, remote, fuses
// - Source chosen by mode pins or control
// - Data served on DDC at address 0xA0
// - Local mode hands DDC to external EEPROM
// - SRAM holds 256 bytes, loaded by master
// - SRAM writable and readable during operation
// - Remote mode reads far EEPROM at 0xA0
// - Remote data copied into SRAM, served there
// - Fuse mode copies 256 bytes at start-up
// - Fuse-loaded SRAM readable over DDC
// - Control channel carries I2C across link
// - Bridged I2C survives multi-master arbitration
// - Hot-plug held low until ready and +5 V present
`timescale 1ns/10ps

package edid_pkg;
  //--------------------------------------------------------------
  // Sizes and addresses
  //--------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int DEPTH = 256;
  localparam logic [7:0] EDID_ADDR = 8'hA0;
  localparam logic [7:0] LAST_BYTE = 8'hFF;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  //--------------------------------------------------------------
  // Timing
  //--------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int RETRY_US = 10;
  localparam int RETRY_CYCLES = RETRY_US * CLK_MHZ;
  localparam logic [15:0] RETRY_LOAD = 16'(RETRY_CYCLES);
  //--------------------------------------------------------------
  // Types
  //--------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_LOCAL = 2'h0,
    MODE_SRAM = 2'h1,
    MODE_REMOTE = 2'h2,
    MODE_FUSE = 2'h3
  } edid_mode_t;
  typedef enum logic [2:0] {
    DDC_IDLE = 3'h0,
    DDC_ADDR = 3'h1,
    DDC_ACK_ADDR = 3'h2,
    DDC_PTR = 3'h3,
    DDC_ACK_PTR = 3'h4,
    DDC_WIGN = 3'h5,
    DDC_TX = 3'h6,
    DDC_RACK = 3'h7
  } ddc_state_t;
  typedef enum logic [2:0] {
    FILL_IDLE = 3'h0,
    FILL_FUSE = 3'h1,
    FILL_REQ = 3'h2,
    FILL_WAIT = 3'h3,
    FILL_BACKOFF = 3'h4
  } fill_state_t;
endpackage

module edid_delivery_and_hotplug (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // DDC from the video source (open drain)
  input wire logic ddc_scl_in,
  input wire logic ddc_sda_in,
  output logic ddc_sda_out,
  output logic ddc_sda_oe,
  // Hot-plug and +5 V
  input wire logic rx_5v_in,
  output logic hpd_out,
  output logic hpd_oe,
  // Mode selection
  input wire logic [1:0] mode_sel_pins,
  input wire logic mode_ctl_en,
  input wire logic [1:0] mode_ctl,
  output logic [1:0] active_mode,
  output logic local_eeprom_sel,
  output logic edid_ready,
  // Host access to identification SRAM
  input wire logic sram_wr_en,
  input wire logic sram_rd_en,
  input wire logic [7:0] sram_addr,
  input wire logic [7:0] sram_wdata,
  output logic [7:0] sram_rdata,
  output logic sram_rd_valid,
  output logic sram_busy,
  // Fuse array
  output logic [7:0] fuse_addr,
  input wire logic [7:0] fuse_data,
  // Bidirectional control channel requests
  output logic bidir_control_channel_req,
  output logic [7:0] bidir_control_channel_dev_addr,
  output logic [7:0] bidir_control_channel_offset,
  input wire logic bidir_control_channel_done,
  input wire logic bidir_control_channel_ack,
  input wire logic bidir_control_channel_arb_lost,
  input wire logic [7:0] bidir_control_channel_rdata
);

  logic [1:0] scl_sync_reg, sda_sync_reg, v5_sync_reg;
  logic [1:0] pin_s1_reg, pin_s2_reg;
  logic scl_last_reg, sda_last_reg;
  edid_pkg::ddc_state_t st_reg, st_next;
  logic [7:0] sh_reg, sh_next, ptr_reg, ptr_next;
  logic [3:0] cnt_reg, cnt_next;
  logic rw_reg, rw_next, nack_reg, nack_next, oe_reg, oe_next;
  edid_pkg::fill_state_t fst_reg, fst_next;
  edid_pkg::edid_mode_t mode_reg;
  logic [7:0] fcnt_reg, fcnt_next;
  logic [15:0] tmr_reg, tmr_next;
  logic ready_reg, ready_next, req_reg, req_next;
  logic busy_reg, hpd_oe_reg, local_reg, rd_valid_reg;
  logic [7:0] ddc_rdata;

  //--------------------------------------------------------------
  // Bus condition decode
  //--------------------------------------------------------------
  wire scl = scl_sync_reg[1];
  wire sda = sda_sync_reg[1];
  wire scl_rise = scl & ~scl_last_reg;
  wire scl_fall = ~scl & scl_last_reg;
  wire start_cond = scl & scl_last_reg & sda_last_reg & ~sda;
  wire stop_cond = scl & scl_last_reg & ~sda_last_reg & sda;
  wire byte_done = (cnt_reg == edid_pkg::BYTE_BITS);
  wire serve = (mode_reg != edid_pkg::MODE_LOCAL) & ready_reg;
  wire addr_hit = (sh_reg[7:1] == edid_pkg::EDID_ADDR[7:1]) & serve;
  wire edid_pkg::edid_mode_t mode_now = mode_ctl_en ?
    edid_pkg::edid_mode_t'(mode_ctl) :
    edid_pkg::edid_mode_t'(pin_s2_reg);
  wire mode_change = (mode_now != mode_reg);
  wire last_fill = (fcnt_reg == edid_pkg::LAST_BYTE);

  //--------------------------------------------------------------
  // SRAM write port selection
  //--------------------------------------------------------------
  wire remote_wr = (fst_reg == edid_pkg::FILL_WAIT) &
    bidir_control_channel_done & bidir_control_channel_ack &
    ~bidir_control_channel_arb_lost & ~mode_change;
  wire fuse_wr = (fst_reg == edid_pkg::FILL_FUSE) & ~mode_change;
  wire fill_wr = remote_wr | fuse_wr;
  wire host_wr = sram_wr_en & ~busy_reg;
  wire mem_wr = fill_wr | host_wr;
  wire [7:0] mem_waddr = fill_wr ? fcnt_reg : sram_addr;
  wire [7:0] mem_wdata = fuse_wr ? fuse_data :
    (remote_wr ? bidir_control_channel_rdata : sram_wdata);

  edid_ram u_ram (
    .clk(clk),
    .wr_en(mem_wr),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_addr_a(sram_addr),
    .rd_data_a(sram_rdata),
    .rd_addr_b(ptr_reg),
    .rd_data_b(ddc_rdata)
  );

  //--------------------------------------------------------------
  // DDC slave
  //--------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    ptr_next = ptr_reg;
    rw_next = rw_reg;
    nack_next = nack_reg;
    if (stop_cond) begin
      st_next = edid_pkg::DDC_IDLE;
    end else if (start_cond) begin
      st_next = edid_pkg::DDC_ADDR;
      cnt_next = 4'h0;
    end else begin
      case (st_reg)
        edid_pkg::DDC_ADDR, edid_pkg::DDC_PTR, edid_pkg::DDC_WIGN: begin
          if (scl_rise && !byte_done) begin
            sh_next = {sh_reg[6:0], sda};
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && byte_done) begin
            cnt_next = 4'h0;
            if (st_reg == edid_pkg::DDC_ADDR) begin
              rw_next = sh_reg[0];
              st_next = addr_hit ? edid_pkg::DDC_ACK_ADDR :
                edid_pkg::DDC_IDLE;
            end else begin
              if (st_reg == edid_pkg::DDC_PTR) begin
                ptr_next = sh_reg;
              end
              st_next = edid_pkg::DDC_ACK_PTR;
            end
          end
        end
        edid_pkg::DDC_ACK_ADDR: begin
          if (scl_fall) begin
            if (rw_reg) begin
              st_next = edid_pkg::DDC_TX;
              sh_next = ddc_rdata;
            end else begin
              st_next = edid_pkg::DDC_PTR;
            end
          end
        end
        edid_pkg::DDC_ACK_PTR: begin
          if (scl_fall) begin
            st_next = edid_pkg::DDC_WIGN;
          end
        end
        edid_pkg::DDC_TX: begin
          if (scl_fall) begin
            sh_next = {sh_reg[6:0], 1'b0};
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == edid_pkg::LAST_TX_BIT) begin
              st_next = edid_pkg::DDC_RACK;
              cnt_next = 4'h0;
              ptr_next = ptr_reg + 8'h01;
            end
          end
        end
        edid_pkg::DDC_RACK: begin
          if (scl_rise) begin
            nack_next = sda;
          end else if (scl_fall) begin
            st_next = nack_reg ? edid_pkg::DDC_IDLE : edid_pkg::DDC_TX;
            sh_next = ddc_rdata;
          end
        end
        default: begin
        end
      endcase
    end
    oe_next = (st_next == edid_pkg::DDC_ACK_ADDR) |
      (st_next == edid_pkg::DDC_ACK_PTR) |
      ((st_next == edid_pkg::DDC_TX) & ~sh_next[7]);
  end

  //--------------------------------------------------------------
  // Fill engine: fuses or remote EEPROM into SRAM
  //--------------------------------------------------------------
  always_comb begin
    fst_next = fst_reg;
    fcnt_next = fcnt_reg;
    ready_next = ready_reg;
    req_next = req_reg;
    tmr_next = tmr_reg;
    if (mode_change) begin
      fst_next = edid_pkg::FILL_IDLE;
      fcnt_next = 8'h00;
      ready_next = 1'b0;
      req_next = 1'b0;
    end else begin
      case (fst_reg)
        edid_pkg::FILL_IDLE: begin
          if (!ready_reg) begin
            if (mode_reg == edid_pkg::MODE_FUSE) begin
              fst_next = edid_pkg::FILL_FUSE;
            end else if (mode_reg == edid_pkg::MODE_REMOTE) begin
              fst_next = edid_pkg::FILL_REQ;
            end else begin
              ready_next = 1'b1;
            end
          end
        end
        edid_pkg::FILL_FUSE: begin
          fcnt_next = fcnt_reg + 8'h01;
          if (last_fill) begin
            fst_next = edid_pkg::FILL_IDLE;
            ready_next = 1'b1;
          end
        end
        edid_pkg::FILL_REQ: begin
          req_next = 1'b1;
          fst_next = edid_pkg::FILL_WAIT;
        end
        edid_pkg::FILL_WAIT: begin
          if (bidir_control_channel_done) begin
            req_next = 1'b0;
            if (bidir_control_channel_arb_lost ||
                !bidir_control_channel_ack) begin
              fst_next = edid_pkg::FILL_BACKOFF;
              tmr_next = edid_pkg::RETRY_LOAD;
            end else if (last_fill) begin
              fst_next = edid_pkg::FILL_IDLE;
              ready_next = 1'b1;
            end else begin
              fcnt_next = fcnt_reg + 8'h01;
              fst_next = edid_pkg::FILL_REQ;
            end
          end
        end
        edid_pkg::FILL_BACKOFF: begin
          tmr_next = tmr_reg - 16'h0001;
          if (tmr_reg == 16'h0000) begin
            fst_next = edid_pkg::FILL_REQ;
          end
        end
        default: begin
          fst_next = edid_pkg::FILL_IDLE;
        end
      endcase
    end
  end

  //--------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      v5_sync_reg <= 2'h0;
      pin_s1_reg <= 2'h0;
      pin_s2_reg <= 2'h0;
      scl_last_reg <= 1'b1;
      sda_last_reg <= 1'b1;
      st_reg <= edid_pkg::DDC_IDLE;
      sh_reg <= 8'h00;
      cnt_reg <= 4'h0;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      oe_reg <= 1'b0;
      fst_reg <= edid_pkg::FILL_IDLE;
      mode_reg <= edid_pkg::MODE_LOCAL;
      fcnt_reg <= 8'h00;
      tmr_reg <= 16'h0000;
      ready_reg <= 1'b0;
      req_reg <= 1'b0;
      busy_reg <= 1'b0;
      hpd_oe_reg <= 1'b1;
      local_reg <= 1'b0;
      rd_valid_reg <= 1'b0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], ddc_scl_in};
      sda_sync_reg <= {sda_sync_reg[0], ddc_sda_in};
      v5_sync_reg <= {v5_sync_reg[0], rx_5v_in};
      pin_s1_reg <= mode_sel_pins;
      pin_s2_reg <= pin_s1_reg;
      scl_last_reg <= scl;
      sda_last_reg <= sda;
      st_reg <= st_next;
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      nack_reg <= nack_next;
      oe_reg <= oe_next;
      fst_reg <= fst_next;
      mode_reg <= mode_now;
      fcnt_reg <= fcnt_next;
      tmr_reg <= tmr_next;
      ready_reg <= ready_next;
      req_reg <= req_next;
      busy_reg <= (fst_next != edid_pkg::FILL_IDLE);
      hpd_oe_reg <= ~(v5_sync_reg[1] & ready_next);
      local_reg <= (mode_now == edid_pkg::MODE_LOCAL);
      rd_valid_reg <= sram_rd_en;
    end
  end

  //--------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------
  assign ddc_sda_out = 1'b0;
  assign ddc_sda_oe = oe_reg;
  assign hpd_out = 1'b0;
  assign hpd_oe = hpd_oe_reg;
  assign active_mode = mode_reg;
  assign local_eeprom_sel = local_reg;
  assign edid_ready = ready_reg;
  assign sram_rd_valid = rd_valid_reg;
  assign sram_busy = busy_reg;
  assign fuse_addr = fcnt_reg;
  assign bidir_control_channel_req = req_reg;
  assign bidir_control_channel_dev_addr = edid_pkg::EDID_ADDR;
  assign bidir_control_channel_offset = fcnt_reg;

endmodule

// File: edid_monitor.sv
// Port-level concurrent checks for the identification delivery block
`timescale 1ns/10ps

module edid_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Hot-plug and DDC
  input wire logic rx_5v_in,
  input wire logic hpd_oe,
  input wire logic ddc_sda_oe,
  // Mode and fill
  input wire logic [1:0] active_mode,
  input wire logic local_eeprom_sel,
  input wire logic edid_ready,
  input wire logic sram_busy,
  input wire logic [7:0] fuse_addr,
  // Host reads
  input wire logic sram_rd_en,
  input wire logic sram_rd_valid,
  // Control channel
  input wire logic bidir_control_channel_req,
  input wire logic [7:0] bidir_control_channel_dev_addr,
  input wire logic [7:0] bidir_control_channel_offset,
  input wire logic bidir_control_channel_done,
  input wire logic bidir_control_channel_ack,
  input wire logic bidir_control_channel_arb_lost
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_HPD_NOTREADY: assert property (!edid_ready |-> hpd_oe)
    else $error("hot-plug released while not ready");
  AST_HPD_NO5V: assert property (!rx_5v_in [*5] |-> hpd_oe)
    else $error("hot-plug released without supply");
  AST_CHAN_ADDR: assert property (bidir_control_channel_req |->
    bidir_control_channel_dev_addr == 8'hA0)
    else $error("remote request to wrong device");
  AST_CHAN_STEP: assert property (bidir_control_channel_req &&
    bidir_control_channel_done && bidir_control_channel_ack &&
    !bidir_control_channel_arb_lost && bidir_control_channel_offset != 8'hFF
    |=> bidir_control_channel_offset ==
    $past(bidir_control_channel_offset) + 8'h01)
    else $error("remote offset did not advance");
  AST_BACKOFF: assert property (bidir_control_channel_req &&
    bidir_control_channel_done && bidir_control_channel_arb_lost
    |=> (!bidir_control_channel_req &&
    $stable(bidir_control_channel_offset)) [*8])
    else $error("no backoff after lost arbitration");
  AST_FUSE_STEP: assert property (sram_busy && active_mode == 2'h3
    && fuse_addr != 8'hFF ##1 active_mode == 2'h3
    |-> fuse_addr == $past(fuse_addr) + 8'h01)
    else $error("fuse copy skipped a byte");
  AST_FUSE_DONE: assert property (sram_busy && active_mode == 2'h3
    && fuse_addr == 8'hFF |=> edid_ready && !sram_busy)
    else $error("fuse copy did not finish after last byte");
  AST_LOCAL_QUIET: assert property (local_eeprom_sel |-> !ddc_sda_oe)
    else $error("device drives DDC in local mode");
  AST_RD_VALID: assert property (sram_rd_en |=> sram_rd_valid)
    else $error("host read not answered");
endmodule

bind edid_delivery_and_hotplug edid_monitor chk (
  .clk(clk), .rst(rst), .rx_5v_in(rx_5v_in), .hpd_oe(hpd_oe),
  .ddc_sda_oe(ddc_sda_oe), .active_mode(active_mode),
  .local_eeprom_sel(local_eeprom_sel), .edid_ready(edid_ready),
  .sram_busy(sram_busy), .fuse_addr(fuse_addr), .sram_rd_en(sram_rd_en),
  .sram_rd_valid(sram_rd_valid),
  .bidir_control_channel_req(bidir_control_channel_req),
  .bidir_control_channel_dev_addr(bidir_control_channel_dev_addr),
  .bidir_control_channel_offset(bidir_control_channel_offset),
  .bidir_control_channel_done(bidir_control_channel_done),
  .bidir_control_channel_ack(bidir_control_channel_ack),
  .bidir_control_channel_arb_lost(bidir_control_channel_arb_lost)
);

// File: edid_ram.sv
// Identification SRAM: one write port, two registered read ports
`timescale 1ns/10ps

module edid_ram (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic wr_en,
  input wire logic [edid_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [edid_pkg::DATA_W-1:0] wr_data,
  // Host read port
  input wire logic [edid_pkg::ADDR_W-1:0] rd_addr_a,
  output logic [edid_pkg::DATA_W-1:0] rd_data_a,
  // DDC read port
  input wire logic [edid_pkg::ADDR_W-1:0] rd_addr_b,
  output logic [edid_pkg::DATA_W-1:0] rd_data_b
);

  logic [edid_pkg::DATA_W-1:0] mem [0:edid_pkg::DEPTH-1];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_a <= mem[rd_addr_a];
    rd_data_b <= mem[rd_addr_b];
  end

endmodule

// File: testbench.sv
// Self-checking bench for the identification delivery block
`timescale 1ns/10ps

module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rx_5v_in = 1'b0;
  logic [1:0] mode_sel_pins = 2'h3;
  logic mode_ctl_en = 1'b0;
  logic [1:0] mode_ctl = 2'h0;
  logic sram_wr_en = 1'b0;
  logic sram_rd_en = 1'b0;
  logic [7:0] sram_addr = 8'h00;
  logic [7:0] sram_wdata = 8'h00;
  logic bidir_control_channel_done = 1'b0;
  logic bidir_control_channel_ack = 1'b0;
  logic bidir_control_channel_arb_lost = 1'b0;
  logic [7:0] bidir_control_channel_rdata = 8'h00;
  logic lose_once = 1'b1;
  logic scl, sda_low, ddc_sda_oe, hpd_oe, local_eeprom_sel, edid_ready;
  logic ddc_sda_out, hpd_out;
  logic sram_rd_valid, sram_busy, bidir_control_channel_req;
  logic [1:0] active_mode;
  logic [7:0] sram_rdata, fuse_addr, bidir_control_channel_offset;
  logic [7:0] bidir_control_channel_dev_addr;
  wire [7:0] fuse_data = fuse_addr ^ 8'h5C;
  wire sda_line = !(sda_low | ddc_sda_oe);
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;

  edid_delivery_and_hotplug uut (
    .clk(clk), .rst(rst), .ddc_scl_in(scl), .ddc_sda_in(sda_line),
    .ddc_sda_out(ddc_sda_out), .ddc_sda_oe(ddc_sda_oe),
    .rx_5v_in(rx_5v_in), .hpd_out(hpd_out), .hpd_oe(hpd_oe),
    .mode_sel_pins(mode_sel_pins),
    .mode_ctl_en(mode_ctl_en), .mode_ctl(mode_ctl),
    .active_mode(active_mode), .local_eeprom_sel(local_eeprom_sel),
    .edid_ready(edid_ready), .sram_wr_en(sram_wr_en),
    .sram_rd_en(sram_rd_en), .sram_addr(sram_addr),
    .sram_wdata(sram_wdata), .sram_rdata(sram_rdata),
    .sram_rd_valid(sram_rd_valid), .sram_busy(sram_busy),
    .fuse_addr(fuse_addr), .fuse_data(fuse_data),
    .bidir_control_channel_req(bidir_control_channel_req),
    .bidir_control_channel_dev_addr(bidir_control_channel_dev_addr),
    .bidir_control_channel_offset(bidir_control_channel_offset),
    .bidir_control_channel_done(bidir_control_channel_done),
    .bidir_control_channel_ack(bidir_control_channel_ack),
    .bidir_control_channel_arb_lost(bidir_control_channel_arb_lost),
    .bidir_control_channel_rdata(bidir_control_channel_rdata)
  );

  ddc_source src (.clk(clk), .sda_line(sda_line), .scl(scl),
    .sda_low(sda_low));

  initial begin
    forever #5 clk = ~clk;
  end

  // Remote side: first request loses arbitration, then all succeed
  always @(posedge clk) begin
    bidir_control_channel_done <= bidir_control_channel_req &&
      !bidir_control_channel_done;
    if (bidir_control_channel_req && !bidir_control_channel_done) begin
      bidir_control_channel_ack <= 1'b1;
      bidir_control_channel_arb_lost <= lose_once;
      bidir_control_channel_rdata <= bidir_control_channel_offset ^ 8'hC3;
      lose_once <= 1'b0;
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wait_ready(output int n);
    n = 0;
    repeat (5) @(posedge clk);
    #1;
    while (edid_ready !== 1'b1 && n < 4000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(32'(edid_ready), 32'h1);
  endtask

  task automatic set_mode(input logic [1:0] m);
    @(posedge clk);
    mode_ctl_en <= 1'b1;
    mode_ctl <= m;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic t_fuse();
    int n;
    logic ok;
    logic [31:0] q;
    chk(32'(hpd_oe), 32'h1);
    wait_ready(n);
    chk(32'(active_mode), 32'h3);
    chk(32'(hpd_oe), 32'h1);
    chk({30'h0, hpd_out, ddc_sda_out}, 32'h0);
    @(posedge clk);
    rx_5v_in <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk(32'(hpd_oe), 32'h0);
    src.xfer(8'hFE, 3, ok, q);
    chk(32'(ok), 32'h1);
    chk(q, {8'h0, 8'hFE ^ 8'h5C, 8'hFF ^ 8'h5C, 8'h5C});
    $display("test fuse done");
  endtask

  task automatic t_local();
    logic ok;
    logic [31:0] q;
    set_mode(edid_pkg::MODE_LOCAL);
    chk(32'(active_mode), 32'h0);
    chk(32'(local_eeprom_sel), 32'h1);
    src.xfer(8'h00, 0, ok, q);
    chk(32'(ok), 32'h0);
    $display("test local done");
  endtask

  task automatic t_sram();
    int n;
    logic ok;
    logic [31:0] q;
    set_mode(edid_pkg::MODE_SRAM);
    wait_ready(n);
    @(posedge clk);
    sram_wr_en <= 1'b1;
    sram_addr <= 8'h10;
    sram_wdata <= 8'h5A;
    @(posedge clk);
    sram_addr <= 8'h11;
    sram_wdata <= 8'hA5;
    @(posedge clk);
    sram_wr_en <= 1'b0;
    sram_rd_en <= 1'b1;
    sram_addr <= 8'h10;
    @(posedge clk);
    sram_rd_en <= 1'b0;
    #1;
    chk({23'h0, sram_rd_valid, sram_rdata}, 32'h15A);
    src.xfer(8'h10, 2, ok, q);
    chk(q, 32'h00005AA5);
    $display("test sram done");
  endtask

  task automatic t_remote();
    int n;
    logic ok;
    logic [31:0] q;
    set_mode(edid_pkg::MODE_REMOTE);
    wait_ready(n);
    chk(32'(n > edid_pkg::RETRY_CYCLES), 32'h1);
    chk(32'(bidir_control_channel_dev_addr), 32'(edid_pkg::EDID_ADDR));
    src.xfer(8'hFF, 2, ok, q);
    chk(32'(ok), 32'h1);
    chk(q, {16'h0, 8'hFF ^ 8'hC3, 8'h00 ^ 8'hC3});
    $display("test remote done");
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_fuse();
    t_local();
    t_sram();
    t_remote();
    final_report();
  end
endmodule
